// ===== shared/sdbi_pkg.sv
// Functional notes
// R1: A new read may follow or cut a read; data keeps flowing without gaps.
// R2: A read command is accepted on any cycle after a previous read.
// R3: Controller may start a write right after the last wanted read data.
// R4: Controller inserts an idle cycle if its drivers could clash with ours.
// R5: Mask raised two clocks before a write suppresses read output drivers.
// R6: A registered write puts data pins in high impedance regardless of mask.
// R7: Mask acts on write inputs with zero latency.
// R8: With latency one, mask is not needed for read to write turnaround.
// R9: A precharge to the same bank ends a read, issued latency minus one early.
// R10: Controller waits the precharge period before commanding that bank again.
// R11: Auto-precharge never shortens a fixed burst and ignores full-page bursts.
// R12: Controller must not interrupt a burst started with auto-precharge.
// R13: Burst terminate ends a read, issued latency minus one cycles early.
// R14: Write data is captured with the command and on each following edge.
// R15: After a completed fixed write the pins stay released, input ignored.
// R16: Full-page bursts run until terminated and wrap the column to zero.
// R17: A new write may cut a write; its coincident data belongs to it.
// R18: A read cutting a write stops all writes from its own edge onward.
// R19: Controller waits write recovery time before precharging after a write.
// R20: Two-clock recovery variant needs at least two clocks before precharge.
// R21: Controller masks data on the precharge edge that cuts a write.
// R22: Read latency may be one, two or three cycles.
// R23: First read data appears latency after the command, then one per cycle.
// R24: Mask high during reads releases the pins two clocks later.
// R25: Write data with mask low is stored; mask high leaves the location alone.
// R26: Controller rounds minimum times up to whole clock cycles.
package sdbi_pkg;
  localparam int DATA_W = 8;
  localparam int COL_W = 9;
  localparam int ROW_W = 11;
  localparam int BANKS = 2;
  localparam int COLS = 512;
  localparam int FIFO_DEPTH = 32;
  localparam int MASK_LAT = 2;
  localparam logic [8:0] COL_LAST = 9'h1FF;
  localparam logic [8:0] COL_ZERO = 9'h000;
  localparam logic [3:0] FULL_PAGE_LEN = 4'h0;
  localparam logic [1:0] CAS_MIN = 2'h1;
  localparam logic [1:0] CAS_MAX = 2'h3;
  localparam logic [3:0] LEN_ZERO = 4'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  typedef enum logic [2:0] {
    SDBI_CMD_NOP,
    SDBI_CMD_READ,
    SDBI_CMD_WRITE,
    SDBI_CMD_PRECHARGE,
    SDBI_CMD_TERMINATE
  } sdbi_cmd_t;
endpackage

// ===== verilog/sdbi_fifo.sv
`timescale 1ns/1ps
module sdbi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready_out = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_out = (count_reg != '0);
  assign out_data_out = mem_reg[rd_ptr_reg];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ===== verilog/sdbi_bank_state.sv
`timescale 1ns/1ps
module sdbi_bank_state (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic precharge_in,
  input wire logic auto_done_in,
  input wire logic [7:0] precharge_cycles_in,
  output logic busy_out
);
  logic [7:0] cnt_reg;

  // Counts down the precharge period after an explicit or automatic precharge.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_reg <= 8'h00;
    end else if (precharge_in || auto_done_in) begin
      cnt_reg <= precharge_cycles_in;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end

  assign busy_out = (cnt_reg != 8'h00);
endmodule

// ===== verilog/sdbi_core.sv
`timescale 1ns/1ps
module sdbi_core
  import sdbi_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic [2:0] cmd_in,
  input wire logic bank_in,
  input wire logic [COL_W-1:0] col_in,
  input wire logic autoprecharge_select_bit_in,
  input wire logic data_mask_in,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe_out,
  input wire logic [1:0] cas_latency_setting_in,
  input wire logic [3:0] burst_len_in,
  input wire logic [7:0] precharge_cycles_in,
  output logic wr_valid_out,
  input wire logic wr_ready_in,
  output logic wr_bank_out,
  output logic [COL_W-1:0] wr_col_out,
  output logic [DATA_W-1:0] wr_data_out,
  input wire logic [DATA_W-1:0] rd_data_in,
  output logic rd_bank_out,
  output logic [COL_W-1:0] rd_col_out,
  output logic bank_busy_out,
  output logic cmd_stall_out
);
  localparam int FW = 1 + COL_W + DATA_W;

  logic [2:0] cmd_s1_reg;
  logic [2:0] cmd_s2_reg;
  logic bank_s1_reg;
  logic bank_s2_reg;
  logic [COL_W-1:0] col_s1_reg;
  logic [COL_W-1:0] col_s2_reg;
  logic ap_s1_reg;
  logic ap_s2_reg;
  logic dm_s1_reg;
  logic dm_s2_reg;
  logic [DATA_W-1:0] dq_s1_reg;
  logic [DATA_W-1:0] dq_s2_reg;

  sdbi_cmd_t cmd;
  logic is_read;
  logic is_write;
  logic is_pre;
  logic is_term;

  logic rd_active_reg;
  logic rd_bank_reg;
  logic rd_ap_reg;
  logic [COL_W-1:0] rd_col_reg;
  logic [3:0] rd_left_reg;
  logic wr_active_reg;
  logic wr_bank_reg;
  logic wr_ap_reg;
  logic [COL_W-1:0] wr_col_reg;
  logic [3:0] wr_left_reg;

  logic [2:0] pipe_vld_reg;
  logic [DATA_W-1:0] pipe_dat_reg [3];
  logic [MASK_LAT-1:0] dm_pipe_reg;
  logic [DATA_W-1:0] dq_reg;
  logic dq_oe_reg;

  logic wr_capture;
  logic [COL_W-1:0] cap_col;
  logic cap_bank;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [FW-1:0] fifo_out_data;
  logic [1:0] auto_done;
  logic [1:0] busy;
  logic [1:0] pre_bank;
  logic [COL_W-1:0] rd_col_cur;
  logic [1:0] cas_lat;

  // Two-flop synchronisers for every pin input.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cmd_s1_reg <= 3'h0;
      cmd_s2_reg <= 3'h0;
      bank_s1_reg <= 1'b0;
      bank_s2_reg <= 1'b0;
      col_s1_reg <= COL_ZERO;
      col_s2_reg <= COL_ZERO;
      ap_s1_reg <= 1'b0;
      ap_s2_reg <= 1'b0;
      dm_s1_reg <= 1'b0;
      dm_s2_reg <= 1'b0;
      dq_s1_reg <= DATA_ZERO;
      dq_s2_reg <= DATA_ZERO;
    end else begin
      cmd_s1_reg <= cmd_in;
      cmd_s2_reg <= cmd_s1_reg;
      bank_s1_reg <= bank_in;
      bank_s2_reg <= bank_s1_reg;
      col_s1_reg <= col_in;
      col_s2_reg <= col_s1_reg;
      ap_s1_reg <= autoprecharge_select_bit_in;
      ap_s2_reg <= ap_s1_reg;
      dm_s1_reg <= data_mask_in;
      dm_s2_reg <= dm_s1_reg;
      dq_s1_reg <= dq_in;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  // Decodes the command; a command is accepted on every cycle.
  always_comb begin
    case (cmd_s2_reg)
      3'h1: cmd = SDBI_CMD_READ;
      3'h2: cmd = SDBI_CMD_WRITE;
      3'h3: cmd = SDBI_CMD_PRECHARGE;
      3'h4: cmd = SDBI_CMD_TERMINATE;
      default: cmd = SDBI_CMD_NOP;
    endcase
  end
  assign is_read = (cmd == SDBI_CMD_READ); // see R2
  assign is_write = (cmd == SDBI_CMD_WRITE);
  assign is_pre = (cmd == SDBI_CMD_PRECHARGE);
  assign is_term = (cmd == SDBI_CMD_TERMINATE);

  // Latency setting clamped to one, two or three cycles.
  assign cas_lat = (cas_latency_setting_in < CAS_MIN) ? CAS_MIN :
                   cas_latency_setting_in; // see R22

  // Read burst column sequencer.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_active_reg <= 1'b0;
      rd_bank_reg <= 1'b0;
      rd_ap_reg <= 1'b0;
      rd_col_reg <= COL_ZERO;
      rd_left_reg <= LEN_ZERO;
    end else if (is_read) begin
      // A new read replaces the running one; data continues without a gap.
      rd_active_reg <= 1'b1; // see R1
      rd_bank_reg <= bank_s2_reg;
      rd_ap_reg <= ap_s2_reg && (burst_len_in != FULL_PAGE_LEN); // see R11
      rd_col_reg <= col_s2_reg + COL_W'(1);
      rd_left_reg <= burst_len_in - 4'h1;
    end else if (is_write || is_term || (is_pre && bank_s2_reg == rd_bank_reg)) begin
      rd_active_reg <= 1'b0; // see R9 see R13
    end else if (rd_active_reg) begin
      // Full-page bursts wrap the column and never end by themselves.
      rd_col_reg <= (rd_col_reg == COL_LAST) ? COL_ZERO : rd_col_reg + COL_W'(1); // see R16
      if (burst_len_in != FULL_PAGE_LEN) begin
        rd_left_reg <= rd_left_reg - 4'h1;
        if (rd_left_reg == LEN_ZERO) begin
          rd_active_reg <= 1'b0;
        end
      end
    end
  end

  assign rd_col_cur = is_read ? col_s2_reg : rd_col_reg;
  assign rd_col_out = rd_col_cur;
  assign rd_bank_out = is_read ? bank_s2_reg : rd_bank_reg;

  // Read data pipeline: data leaves the array now and reaches the pins after the latency.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pipe_vld_reg <= 3'h0;
      pipe_dat_reg[0] <= DATA_ZERO;
      pipe_dat_reg[1] <= DATA_ZERO;
      pipe_dat_reg[2] <= DATA_ZERO;
    end else begin
      pipe_vld_reg[0] <= (is_read || (rd_active_reg && !is_write && !is_term &&
                         !(is_pre && bank_s2_reg == rd_bank_reg) &&
                         !(burst_len_in != FULL_PAGE_LEN && rd_left_reg == LEN_ZERO)));
      pipe_dat_reg[0] <= rd_data_in;
      pipe_vld_reg[2:1] <= pipe_vld_reg[1:0];
      pipe_dat_reg[1] <= pipe_dat_reg[0];
      pipe_dat_reg[2] <= pipe_dat_reg[1];
    end
  end

  // Mask delay line for the output drivers.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dm_pipe_reg <= '0;
    end else begin
      dm_pipe_reg <= {dm_pipe_reg[MASK_LAT-2:0], dm_s2_reg}; // see R5 see R24
    end
  end

  // Output drivers; a write releases the pins at once.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dq_reg <= DATA_ZERO;
      dq_oe_reg <= 1'b0;
    end else begin
      dq_reg <= pipe_dat_reg[cas_lat - 2'h1]; // see R23
      dq_oe_reg <= pipe_vld_reg[cas_lat - 2'h1] && !dm_pipe_reg[MASK_LAT-1] &&
                   !is_write && !wr_active_reg; // see R6 see R24
    end
  end
  assign dq_out = dq_reg;
  assign dq_oe_out = dq_oe_reg;

  // Write burst column sequencer.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_active_reg <= 1'b0;
      wr_bank_reg <= 1'b0;
      wr_ap_reg <= 1'b0;
      wr_col_reg <= COL_ZERO;
      wr_left_reg <= LEN_ZERO;
    end else if (is_write) begin
      // A new write takes over; its coincident data is its own first element.
      wr_active_reg <= (burst_len_in != 4'h1); // see R17
      wr_bank_reg <= bank_s2_reg;
      wr_ap_reg <= ap_s2_reg && (burst_len_in != FULL_PAGE_LEN); // see R11
      wr_col_reg <= col_s2_reg + COL_W'(1);
      wr_left_reg <= burst_len_in - 4'h2;
    end else if (is_read || is_term || (is_pre && bank_s2_reg == wr_bank_reg)) begin
      wr_active_reg <= 1'b0; // see R18
    end else if (wr_active_reg) begin
      wr_col_reg <= (wr_col_reg == COL_LAST) ? COL_ZERO : wr_col_reg + COL_W'(1); // see R16
      if (burst_len_in != FULL_PAGE_LEN) begin
        wr_left_reg <= wr_left_reg - 4'h1;
        if (wr_left_reg == LEN_ZERO) begin
          wr_active_reg <= 1'b0; // see R15
        end
      end
    end
  end

  // Capture on the command edge and each later edge, with zero mask latency.
  assign wr_capture = (is_write || (wr_active_reg && !is_read && !is_term &&
                      !(is_pre && bank_s2_reg == wr_bank_reg))) &&
                      !dm_s2_reg; // see R14 see R7 see R25
  assign cap_col = is_write ? col_s2_reg : wr_col_reg;
  assign cap_bank = is_write ? bank_s2_reg : wr_bank_reg;

  sdbi_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .in_valid_in(wr_capture),
    .in_ready_out(fifo_in_ready),
    .in_data_in({cap_bank, cap_col, dq_s2_reg}),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(wr_ready_in),
    .out_data_out(fifo_out_data)
  );

  assign wr_valid_out = fifo_out_valid;
  assign wr_bank_out = fifo_out_data[FW-1];
  assign wr_col_out = fifo_out_data[FW-2 -: COL_W];
  assign wr_data_out = fifo_out_data[DATA_W-1:0];
  assign cmd_stall_out = !fifo_in_ready;

  // Auto-precharge fires when a fixed burst completes, except a single-beat write, as an explicit one would.
  always_comb begin
    auto_done = 2'b00;
    if (rd_active_reg && rd_ap_reg && rd_left_reg == LEN_ZERO) begin
      auto_done[rd_bank_reg] = 1'b1; // see R11
    end
    if (wr_active_reg && wr_ap_reg && wr_left_reg == LEN_ZERO) begin
      auto_done[wr_bank_reg] = 1'b1;
    end
    pre_bank = 2'b00;
    if (is_pre) begin
      pre_bank[bank_s2_reg] = 1'b1;
    end
  end

  // Per-bank precharge period timers; the controller sees only their OR on bank_busy_out.
  genvar b;
  generate
    for (b = 0; b < BANKS; b++) begin : g_bank
      sdbi_bank_state u_bank (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .precharge_in(pre_bank[b]),
        .auto_done_in(auto_done[b]),
        .precharge_cycles_in(precharge_cycles_in),
        .busy_out(busy[b])
      ); // see R10
    end
  endgenerate
  assign bank_busy_out = |busy;
endmodule

// ===== sim/sdbi_core_sva.sv
`timescale 1ns/1ps
module sdbi_core_sva
  import sdbi_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic [2:0] cmd_in,
  input wire logic data_mask_in,
  input wire logic [1:0] cas_latency_setting_in,
  input wire logic [3:0] burst_len_in,
  input wire logic [7:0] precharge_cycles_in,
  input wire logic dq_oe_out,
  input wire logic wr_valid_out,
  input wire logic wr_ready_in,
  input wire logic [COL_W-1:0] wr_col_out,
  input wire logic [DATA_W-1:0] wr_data_out,
  input wire logic bank_busy_out,
  input wire logic cmd_stall_out
);
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);
  oe_write_off_a: assert property (cmd_in == 3'h2 |-> ##3 (!dq_oe_out) [*2])
    else $error("drivers on after a write");
  oe_mask_off_a: assert property (data_mask_in |-> ##5 !dq_oe_out)
    else $error("drivers on under a mask");
  read_lat_a: assert property ((cmd_in == 3'h1 && cas_latency_setting_in == 2'h2 &&
    burst_len_in == 4'h4 && !data_mask_in) ##1 (cmd_in == 3'h0 && !data_mask_in) [*7]
    |-> dq_oe_out && $past(dq_oe_out) ##3 !dq_oe_out)
    else $error("read burst timing off");
  wr_hold_a: assert property (wr_valid_out && !wr_ready_in |=> wr_valid_out &&
    $stable(wr_col_out) && $stable(wr_data_out))
    else $error("write stream changed while stalled");
  wr_push_a: assert property (cmd_in == 3'h2 && !data_mask_in |-> ##[2:5] wr_valid_out)
    else $error("write data not queued");
  busy_rise_a: assert property (cmd_in == 3'h3 && precharge_cycles_in == 8'h06
    |-> ##[2:4] bank_busy_out)
    else $error("precharge did not mark bank busy");
  busy_hold_a: assert property ($rose(bank_busy_out) && precharge_cycles_in == 8'h06
    |-> bank_busy_out [*5])
    else $error("bank busy too short");
  stall_full_a: assert property (cmd_stall_out |-> wr_valid_out)
    else $error("stall without queued data");
endmodule
bind sdbi_core sdbi_core_sva sdbi_core_sva_i (.clk_sys_in, .resetn_in, .cmd_in, .data_mask_in,
  .cas_latency_setting_in, .burst_len_in, .precharge_cycles_in, .dq_oe_out, .wr_valid_out,
  .wr_ready_in, .wr_col_out, .wr_data_out, .bank_busy_out, .cmd_stall_out);

// ===== sim/sdbi_array_model.sv
`timescale 1ns/1ps
module sdbi_array_model
  import sdbi_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic stall_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic wr_bank_in,
  input wire logic [COL_W-1:0] wr_col_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  input wire logic rd_bank_in,
  input wire logic [COL_W-1:0] rd_col_in,
  output logic [DATA_W-1:0] rd_data_out
);
  logic [DATA_W-1:0] mem [0:1][0:COLS-1];
  initial begin
    for (int b = 0; b < 2; b++) begin
      for (int c = 0; c < COLS; c++) mem[b][c] = 8'(c) ^ ((b == 1) ? 8'h5A : 8'hC3);
    end
  end
  assign wr_ready_out = !stall_in;
  assign rd_data_out = mem[rd_bank_in][rd_col_in];
  always @(posedge clk_sys_in) begin
    if (wr_valid_in && wr_ready_out) mem[wr_bank_in][wr_col_in] <= wr_data_in;
  end
endmodule

// ===== sim/sdram_burst_interaction_tb.sv
`timescale 1ns/1ps
module sdram_burst_interaction_tb;
  import sdbi_pkg::*;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [2:0] cmd_in = 3'h0;
  logic bank_in = 1'b0;
  logic [8:0] col_in = 9'h000;
  logic ap_bit = 1'b0;
  logic data_mask_in = 1'b0;
  logic [7:0] dq_in = 8'h00;
  logic [1:0] cas = 2'h2;
  logic [3:0] blen = 4'h4;
  logic stall = 1'b0;
  logic [7:0] dq_out, rd_data, wr_data;
  logic dq_oe_out, wr_valid, wr_ready, wr_bank, rd_bank, bank_busy_out, cmd_stall_out;
  logic [8:0] wr_col, rd_col;
  logic [7:0] got[$];
  logic busy_seen;
  int first, last, err_total, checks;
  always #2 clk_sys_in = ~clk_sys_in;
  sdbi_core sdbi_core_i (.clk_sys_in, .resetn_in, .cmd_in, .bank_in, .col_in,
    .autoprecharge_select_bit_in(ap_bit), .data_mask_in, .dq_in, .dq_out, .dq_oe_out,
    .cas_latency_setting_in(cas), .burst_len_in(blen), .precharge_cycles_in(8'h06),
    .wr_valid_out(wr_valid), .wr_ready_in(wr_ready), .wr_bank_out(wr_bank),
    .wr_col_out(wr_col), .wr_data_out(wr_data), .rd_data_in(rd_data),
    .rd_bank_out(rd_bank), .rd_col_out(rd_col), .bank_busy_out, .cmd_stall_out);
  sdbi_array_model sdbi_array_model_i (.clk_sys_in, .stall_in(stall), .wr_valid_in(wr_valid),
    .wr_ready_out(wr_ready), .wr_bank_in(wr_bank), .wr_col_in(wr_col), .wr_data_in(wr_data),
    .rd_bank_in(rd_bank), .rd_col_in(rd_col), .rd_data_out(rd_data));
  task tally_and_finish;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t got %0h expected %0h", $time, g, e);
    end
  endtask
  function automatic logic [7:0] pat(input logic b, input logic [8:0] c);
    return c[7:0] ^ (b ? 8'h5A : 8'hC3);
  endfunction
  task put(input logic [2:0] c, input logic [8:0] a, input logic m, input logic [7:0] d,
      input logic bk = 1'b1);
    @(posedge clk_sys_in);
    cmd_in <= c;
    bank_in <= (c != 3'h2) && bk;
    col_in <= a;
    data_mask_in <= m;
    dq_in <= d;
  endtask
  task nop;
    put(3'h0, 9'h000, 1'h0, 8'h00);
  endtask
  task term;
    put(3'h4, 9'h000, 1'h0, 8'h00);
  endtask
  task rd(input logic [8:0] a);
    put(3'h1, a, 1'h0, 8'h00);
  endtask
  task wr(input logic [8:0] a, input logic [7:0] d);
    put(3'h2, a, 1'h0, d);
  endtask
  task dat(input logic m, input logic [7:0] d);
    put(3'h0, 9'h000, m, d);
  endtask
  task mode(input logic [1:0] c, input logic [3:0] b);
    @(posedge clk_sys_in);
    cas <= c;
    blen <= b;
  endtask
  task grab;
    got.delete();
    first = -1;
    busy_seen = 1'b0;
    for (int i = 0; i < 28; i++) begin
      @(posedge clk_sys_in);
      busy_seen = busy_seen | bank_busy_out;
      if (dq_oe_out === 1'b1) begin
        if (first < 0) first = i;
        last = i;
        got.push_back(dq_out);
      end
    end
  endtask
  task automatic cmpq(input logic [8:0] cl[$]);
    chk(got.size(), cl.size());
    foreach (cl[i]) if (i < got.size()) chk(got[i], pat(1'b1, cl[i]));
  endtask
  task mchk(input logic [8:0] a, input logic [7:0] e);
    chk(sdbi_array_model_i.mem[0][a], e);
  endtask
  task drain;
    int i;
    i = 0;
    repeat (4) @(posedge clk_sys_in);
    while (wr_valid === 1'b1 && i < 200) begin
      @(posedge clk_sys_in);
      i++;
    end
    if (i == 200) begin
      err_total++;
      tally_and_finish();
    end
    repeat (2) @(posedge clk_sys_in);
  endtask
  task automatic rd_lat;
    logic [8:0] q[$];
    for (int c = 1; c < 4; c++) begin
      for (int k = 0; k < 4; k++) begin
        mode(2'(c), 4'(1 << k));
        fork
          grab();
          begin
            rd(9'h010);
            nop();
          end
        join
        q.delete();
        for (int i = 0; i < (1 << k); i++) q.push_back(9'h010 + 9'(i));
        cmpq(q);
        chk(first, c + 4);
      end
    end
  endtask
  task rd_cut;
    mode(2'h2, 4'h4);
    fork
      grab();
      begin
        rd(9'h020);
        rd(9'h030);
        nop();
        rd(9'h040);
        nop();
      end
    join
    cmpq('{9'h020, 9'h030, 9'h031, 9'h040, 9'h041, 9'h042, 9'h043});
    chk(last - first, 6);
  endtask
  task wrap_term;
    mode(2'h3, 4'h0);
    fork
      grab();
      begin
        rd(9'h1FE);
        repeat (3) nop();
        term();
        nop();
      end
    join
    cmpq('{9'h1FE, 9'h1FF, 9'h000, 9'h001});
  endtask
  task rd_pre;
    mode(2'h2, 4'h8);
    fork
      grab();
      begin
        rd(9'h050);
        repeat (2) nop();
        put(3'h3, 9'h000, 1'h0, 8'h00);
        nop();
      end
    join
    cmpq('{9'h050, 9'h051, 9'h052});
    chk(busy_seen, 1'b1);
    mode(2'h2, 4'h4);
    ap_bit <= 1'b1;
    fork
      grab();
      begin
        rd(9'h058);
        nop();
      end
    join
    ap_bit <= 1'b0;
    cmpq('{9'h058, 9'h059, 9'h05A, 9'h05B});
  endtask
  task rd_mask;
    mode(2'h2, 4'h8);
    fork
      grab();
      begin
        rd(9'h060);
        repeat (2) nop();
        dat(1'b1, 8'h00);
        nop();
      end
    join
    cmpq('{9'h060, 9'h061, 9'h062, 9'h064, 9'h065, 9'h066, 9'h067});
    chk(last - first, 7);
  endtask
  task rd_wr;
    mode(2'h3, 4'h4);
    fork
      grab();
      begin
        rd(9'h070);
        nop();
        repeat (2) dat(1'b1, 8'h00);
        wr(9'h080, 8'hAA);
        for (int i = 1; i < 4; i++) dat(1'b0, 8'hAA + 8'(i));
        nop();
      end
    join
    cmpq('{9'h070});
    drain();
    for (int i = 0; i < 4; i++) mchk(9'h080 + 9'(i), 8'hAA + 8'(i));
  endtask
  task wr_ops;
    mode(2'h2, 4'h4);
    wr(9'h100, 8'h10);
    dat(1'b0, 8'h11);
    dat(1'b1, 8'h12);
    for (int i = 3; i < 6; i++) dat(1'b0, 8'h10 + 8'(i));
    wr(9'h110, 8'h20);
    dat(1'b0, 8'h21);
    wr(9'h120, 8'h30);
    for (int i = 1; i < 5; i++) dat(1'b0, 8'h30 + 8'(i));
    wr(9'h130, 8'h40);
    dat(1'b0, 8'h41);
    rd(9'h000);
    dat(1'b0, 8'h43);
    nop();
    drain();
    mchk(9'h101, 8'h11);
    mchk(9'h102, pat(1'b0, 9'h102));
    mchk(9'h103, 8'h13);
    mchk(9'h104, pat(1'b0, 9'h104));
    mchk(9'h111, 8'h21);
    mchk(9'h112, pat(1'b0, 9'h112));
    for (int i = 0; i < 4; i++) mchk(9'h120 + 9'(i), 8'h30 + 8'(i));
    mchk(9'h124, pat(1'b0, 9'h124));
    mchk(9'h131, 8'h41);
    mchk(9'h132, pat(1'b0, 9'h132));
  endtask
  task wr_pre;
    mode(2'h1, 4'h8);
    fork
      grab();
      begin
        rd(9'h0A0);
        term();
        nop();
        wr(9'h0C0, 8'h50);
        dat(1'b0, 8'h51);
        dat(1'b1, 8'h52);
        put(3'h3, 9'h000, 1'b1, 8'h53, 1'b0);
        nop();
      end
    join
    cmpq('{9'h0A0});
    chk(busy_seen, 1'b1);
    drain();
    mchk(9'h0C0, 8'h50);
    mchk(9'h0C1, 8'h51);
    mchk(9'h0C2, pat(1'b0, 9'h0C2));
    mchk(9'h0C3, pat(1'b0, 9'h0C3));
  endtask
  task fifo_fill;
    mode(2'h2, 4'h0);
    stall <= 1'b1;
    wr(9'h140, 8'h00);
    for (int i = 1; i < 40; i++) dat(1'b0, 8'(i));
    term();
    nop();
    repeat (4) @(posedge clk_sys_in);
    chk(cmd_stall_out, 1'b1);
    stall <= 1'b0;
    drain();
    for (int i = 0; i < 32; i++) mchk(9'h140 + 9'(i), 8'(i));
  endtask
  initial begin
    repeat (8) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    rd_lat();
    rd_cut();
    wrap_term();
    rd_pre();
    rd_mask();
    rd_wr();
    wr_ops();
    wr_pre();
    fifo_fill();
    tally_and_finish();
  end
endmodule
